// >>> core/adcrts_bank.v
// Bank of four read-only ADC result registers with a shared PWM edge time stamp.
// Assumes all inputs are synchronous to clk_sys; the serial port supplies a
// register index and read strobe and the converter supplies valid strobes.
`include "adcrts_defs.vh"
`default_nettype none
// Operation
// - Each register is 16 bits: stamp in bits 15..10, code in bits 9..0.
// - Shared stamp counter advances on every rising and falling PWM pin edge.
// - A stamp is captured only on a valid conversion of its own channel.
// - The counter wraps from its maximum to zero on the next edge.
// - The code field holds the newest conversion result of its channel.
// - First register carries analog input three.
// - Second register carries analog input five.
// - Third register carries analog input two.
// - Fourth register carries analog input four.
module adcrts_bank (
  input wire clk_sys, // System clock, 125 MHz.
  input wire srst, // Synchronous reset, active high.
  input wire pwm_input_pin, // PWM input level, synchronous to clk_sys.
  input wire [`ADCRTS_DATA_W-1:0] adcCode, // Code from the converter.
  input wire validThree, // Valid conversion of analog_in_three.
  input wire validFive, // Valid conversion of analog_in_five.
  input wire validTwo, // Valid conversion of analog_in_two.
  input wire validFour, // Valid conversion of analog_in_four.
  input wire [1:0] regIndex, // Register index from the serial port.
  input wire regRead, // Read strobe from the serial port.
  input wire regWrite, // Write strobe, ignored by this bank.
  input wire [`ADCRTS_REG_W-1:0] regWdata, // Write data, ignored.
  output reg [`ADCRTS_REG_W-1:0] regRdata, // Read data, registered.
  output reg regRvalid, // Read data valid, one cycle after each read strobe.
  output wire [`ADCRTS_TS_W-1:0] stampCount // Current stamp counter value.
);
  reg pinLast;
  reg [`ADCRTS_TS_W-1:0] stamp;
  wire pinEdge;
  wire [`ADCRTS_REG_W-1:0] code_input_three;
  wire [`ADCRTS_REG_W-1:0] code_input_five;
  wire [`ADCRTS_REG_W-1:0] code_input_two;
  wire [`ADCRTS_REG_W-1:0] code_input_four;
  reg [`ADCRTS_REG_W-1:0] selWord;

  // Any change of the pin level is an edge.
  assign pinEdge = pinLast ^ pwm_input_pin;
  assign stampCount = stamp;

  // Edge counter; reset clears the pin history to low, then it tracks the pin.
  always @(posedge clk_sys) begin
    if (srst) begin
      pinLast <= 1'h0;
      stamp <= `ADCRTS_TS_RST;
    end else begin
      pinLast <= pwm_input_pin;
      if (pinEdge) begin
        if (stamp == `ADCRTS_TS_MAX)
          stamp <= `ADCRTS_TS_RST;
        else
          stamp <= stamp + 6'h01;
      end
    end
  end

  // Channel to register assignment.
  adcrts_slot slotThree (
    .clk_sys(clk_sys), .srst(srst), .capture(validThree),
    .stampNow(stamp), .codeIn(adcCode), .value(code_input_three)
  );
  adcrts_slot slotFive (
    .clk_sys(clk_sys), .srst(srst), .capture(validFive),
    .stampNow(stamp), .codeIn(adcCode), .value(code_input_five)
  );
  adcrts_slot slotTwo (
    .clk_sys(clk_sys), .srst(srst), .capture(validTwo),
    .stampNow(stamp), .codeIn(adcCode), .value(code_input_two)
  );
  adcrts_slot slotFour (
    .clk_sys(clk_sys), .srst(srst), .capture(validFour),
    .stampNow(stamp), .codeIn(adcCode), .value(code_input_four)
  );

  // Read multiplexer by register index.
  always @* begin
    case (regIndex)
      `ADCRTS_IDX_CH3: selWord = code_input_three;
      `ADCRTS_IDX_CH5: selWord = code_input_five;
      `ADCRTS_IDX_CH2: selWord = code_input_two;
      `ADCRTS_IDX_CH4: selWord = code_input_four;
      default: selWord = 16'h0000;
    endcase
  end

  // Read port; writes are not decoded so no write can change a field.
  always @(posedge clk_sys) begin
    if (srst) begin
      regRdata <= 16'h0000;
      regRvalid <= 1'h0;
    end else begin
      regRvalid <= regRead;
      if (regRead)
        regRdata <= selWord;
    end
  end
endmodule
`default_nettype wire

// >>> core/adcrts_defs.vh
// Constants for the ADC result and time stamp register bank.
// Assumes inclusion by bare name from the design files.
`ifndef ADCRTS_DEFS_VH
`define ADCRTS_DEFS_VH
`define ADCRTS_REG_W 16
`define ADCRTS_TS_MSB 15
`define ADCRTS_TS_LSB 10
`define ADCRTS_TS_W 6
`define ADCRTS_DATA_MSB 9
`define ADCRTS_DATA_LSB 0
`define ADCRTS_DATA_W 10
`define ADCRTS_TS_MAX 6'h3f
`define ADCRTS_TS_RST 6'h00
`define ADCRTS_DATA_RST 10'h000
`define ADCRTS_IDX_CH3 2'h0
`define ADCRTS_IDX_CH5 2'h1
`define ADCRTS_IDX_CH2 2'h2
`define ADCRTS_IDX_CH4 2'h3
`define ADCRTS_LSB_UV 3519
`endif

// >>> core/adcrts_slot.v
// One result register: a time stamp field and a conversion data field.
// Assumes the capture strobe is a one-cycle pulse synchronous to clk_sys.
`include "adcrts_defs.vh"
`default_nettype none
module adcrts_slot (
  input wire clk_sys, // System clock.
  input wire srst, // Synchronous reset, active high.
  input wire capture, // Valid conversion of this channel completed.
  input wire [`ADCRTS_TS_W-1:0] stampNow, // Current time stamp count.
  input wire [`ADCRTS_DATA_W-1:0] codeIn, // New conversion code.
  output wire [`ADCRTS_REG_W-1:0] value // Register contents.
);
  reg [`ADCRTS_TS_W-1:0] stamp;
  reg [`ADCRTS_DATA_W-1:0] code;

  // Both fields load together on a valid conversion and otherwise hold.
  always @(posedge clk_sys) begin
    if (srst) begin
      stamp <= `ADCRTS_TS_RST;
      code <= `ADCRTS_DATA_RST;
    end else if (capture) begin
      stamp <= stampNow;
      code <= codeIn;
    end
  end

  // Field placement within the 16-bit word.
  assign value = {stamp, code};
endmodule
`default_nettype wire

// >>> verif/adcrts_assertions.sv
// Checker for the result bank ports.
// Assumes it is bound to adcrts_bank.
`default_nettype none
module adcrts_chk (
  input wire logic clk_sys, // Clock.
  input wire logic srst, // Reset.
  input wire logic pwm_input_pin, // Pin level.
  input wire logic [9:0] adcCode, // Code.
  input wire logic validThree, // Capture strobe.
  input wire logic [1:0] regIndex, // Index.
  input wire logic regRead, // Read strobe.
  input wire logic [15:0] regRdata, // Read data.
  input wire logic regRvalid, // Read valid.
  input wire logic [5:0] stampCount // Counter.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pinLast;
  wire edgeSeen = pwm_input_pin != pinLast;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // Pin history mirrors the bank's, cleared by reset.
  always @(posedge clk_sys) pinLast <= srst ? 1'h0 : pwm_input_pin;
  a_cnt_step: assert property (edgeSeen |=> stampCount == $past(stampCount) + 6'h01)
    else $error("count step");
  a_cnt_hold: assert property (!edgeSeen |=> $stable(stampCount))
    else $error("count moved");
  a_cnt_wrap: assert property (edgeSeen && stampCount == 6'h3f |=> stampCount == 6'h00)
    else $error("no wrap");
  a_rd_answer: assert property (regRead |=> regRvalid)
    else $error("no answer");
  a_rd_quiet: assert property (!regRead |=> !regRvalid && $stable(regRdata))
    else $error("spurious read");
  a_ts_three: assert property (
    validThree ##1 (regRead && regIndex == 2'h0 && !validThree)
    |=> regRdata == {$past(stampCount, 2), $past(adcCode, 2)})
    else $error("slot three");
  a_zero_rel: assert property ($fell(srst) |->
    stampCount == 6'h00 && regRdata == 16'h0000)
    else $error("not cleared");
  a_valid_once: assert property (regRvalid && !$past(regRead) |-> 1'h0)
    else $error("valid held");
  cover property (edgeSeen && stampCount == 6'h3f);
  cover property (validThree ##1 (regRead && regIndex == 2'h0));
  cover property (regRead ##1 regRead);
endmodule
`default_nettype wire

// >>> verif/adcrts_bank_bench.sv
// Self-checking bench for the result bank.
// Assumes the bank and its checker are compiled first.
`default_nettype none
module adcrts_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, srst = 1, pin = 0, rd = 0, wr = 0, rvalid, erv, last;
  logic [3:0] vld = 0;
  logic [9:0] code = 0;
  logic [1:0] idx = 0;
  logic [5:0] cnt, ecnt;
  logic [15:0] wd = 0, rdata, erd, es [4];
  int n_fail = 0, check_count = 0;
  // Host step of one code, in microvolts.
  localparam int LSB_UV = 3519;
  adcrts_bank DUT (.clk_sys(clk_sys), .srst(srst), .pwm_input_pin(pin), .adcCode(code),
    .validThree(vld[0]), .validFive(vld[1]), .validTwo(vld[2]), .validFour(vld[3]),
    .regIndex(idx), .regRead(rd), .regWrite(wr), .regWdata(wd), .regRdata(rdata),
    .regRvalid(rvalid), .stampCount(cnt));
  function automatic logic [15:0] word(input logic [5:0] s, input logic [9:0] c);
    word = {s, c};
  endfunction
  // Host-side scaling of an unsigned code to millivolts.
  function automatic logic [15:0] to_mv(input logic [9:0] c);
    to_mv = 16'((32'(c) * LSB_UV) / 1000);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial forever #4 clk_sys = ~clk_sys;
  // Reference model; slot order is three, five, two, four.
  always @(posedge clk_sys) begin
    if (srst) begin
      ecnt <= 6'h00;
      last <= 1'h0;
      erv <= 1'h0;
      erd <= 16'h0000;
      for (int k = 0; k < 4; k++) es[k] <= 16'h0000;
    end else begin
      for (int k = 0; k < 4; k++) if (vld[k]) es[k] <= word(ecnt, code);
      if (pin != last) ecnt <= ecnt + 6'h01;
      last <= pin;
      erv <= rd;
      if (rd) erd <= es[idx];
    end
  end
  // Random traffic, with reads of every slot first and a reset midway.
  initial begin
    void'($urandom(32'h28b8));
    repeat (8) @(negedge clk_sys);
    srst = 0;
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk_sys);
      check(rdata, erd);
      check({15'h0, rvalid}, {15'h0, erv});
      check({10'h0, cnt}, {10'h0, ecnt});
      if (rvalid) check(to_mv(rdata[9:0]), to_mv(erd[9:0]));
      srst = (i == 1500);
      pin = 1'($urandom);
      vld = (i > 3 && $urandom % 3 == 0) ? 4'($urandom) : 4'h0;
      code = ($urandom % 4 == 0) ? 10'h3ff : 10'($urandom);
      idx = (i < 4) ? i[1:0] : 2'($urandom);
      rd = (i < 4) || (vld == 4'h0 && 1'($urandom));
      wr = 1'($urandom);
      wd = 16'($urandom);
    end
    print_verdict;
  end
  // Watchdog against a hang.
  initial begin
    #100us;
    n_fail++;
    print_verdict;
  end
endmodule
bind adcrts_bank adcrts_chk CHK (.clk_sys(clk_sys), .srst(srst), .pwm_input_pin(pwm_input_pin),
  .adcCode(adcCode), .validThree(validThree), .regIndex(regIndex), .regRead(regRead),
  .regRdata(regRdata), .regRvalid(regRvalid), .stampCount(stampCount));
`default_nettype wire
